// ==== bench/asb_node.sv ====
// Remote serial node on the line
`timescale 1ns/1ps
module asb_node (
  input wire logic clk,
  input wire logic txd,
  output logic rxd
);
  int bit_cyc = 16;
  int nbits = 10;
  int nrx = 0;
  logic [10:0] got;
  initial rxd = 1'b1;
  // Frame goes out lsb first, line returns high
  task automatic send(input logic [10:0] f, input int n);
    for (int i = 0; i < n; i++) begin
      rxd <= f[i];
      repeat (bit_cyc) @(posedge clk);
    end
    rxd <= 1'b1;
  endtask
  // Samples each bit in its middle
  always begin
    @(negedge txd);
    got = '0;
    repeat (bit_cyc / 2) @(posedge clk);
    for (int i = 0; i < nbits; i++) begin
      got[i] = txd;
      repeat (bit_cyc) @(posedge clk);
    end
    nrx++;
  end
endmodule

// ==== bench/asb_serial_chk.sv ====
// Port-level assertions for the serial block
`timescale 1ns/1ps
module asb_serial_chk #(
  parameter int ADR_W = 12
) (
  input wire logic CLK_SYS,
  input wire logic NRST,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [ADR_W-1:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic WB_ACK_O,
  input wire logic RXD,
  input wire logic TXD,
  input wire logic TXD_EN,
  input wire logic IRQ
);
  logic take;
  logic wr;
  logic [7:0] ftx;
  logic [3:0] irq_en;
  logic [8:0] low_cnt;
  assign take = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  assign wr = take && WB_WE_I && WB_SEL_I[0];
  // ----------------------------------------
  // Shadows of written control values
  // ----------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      ftx <= 8'h00;
      irq_en <= 4'h0;
    end else if (wr && WB_ADR_I[11:2] == asb_pkg::IDX_FINE_TX_DIVIDER) begin
      ftx <= WB_DAT_I[7:0];
    end else if (wr && WB_ADR_I[11:2] == asb_pkg::IDX_LINE_CONTROL) begin
      irq_en <= WB_DAT_I[7:4];
    end
  end
  // Length of the current low run on the line
  always_ff @(posedge CLK_SYS) begin
    if (!NRST || TXD) begin
      low_cnt <= 9'h000;
    end else if (low_cnt != 9'h1FF) begin
      low_cnt <= low_cnt + 9'h001;
    end
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!NRST);
  a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack too long");
  a_ack_answer: assert property (take |=> WB_ACK_O) else $error("ack missing");
  a_read_high_zero: assert property (WB_ACK_O |-> WB_DAT_O[31:8] == 24'h000000)
    else $error("upper read bits set");
  a_unmapped_zero: assert property (take && !WB_WE_I && WB_ADR_I[11:2] == 10'h056
    |=> WB_DAT_O == 32'h00000000) else $error("unmapped read not zero");
  a_pin_owner: assert property (wr && WB_ADR_I[11:2] == asb_pkg::IDX_LINE_CONTROL
    |-> ##2 TXD_EN == $past(WB_DAT_I[3], 2)) else $error("pin ownership wrong");
  a_irq_quiet: assert property (irq_en == 4'h0 && $past(irq_en) == 4'h0 |-> !IRQ)
    else $error("irq with enables off");
  a_tx_bit_time: assert property ($rose(TXD) && ftx == 8'h01 |-> low_cnt[3:0] == 4'h0)
    else $error("low run not whole bits");
  a_low_bounded: assert property (low_cnt <= 9'd176 || ftx != 8'h01)
    else $error("low run beyond a frame");
  a_reset_idle: assert property ($rose(NRST) |-> TXD && !TXD_EN && !IRQ)
    else $error("outputs not idle after reset");
  cover property (wr);
  cover property ($rose(TXD) && ftx == 8'h01);
  cover property ($rose(IRQ));
endmodule
bind asb_serial asb_serial_chk #(.ADR_W(ADR_W)) u_chk (.CLK_SYS(CLK_SYS), .NRST(NRST),
  .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I),
  .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
  .RXD(RXD), .TXD(TXD), .TXD_EN(TXD_EN), .IRQ(IRQ));

// ==== bench/tb_top.sv ====
// Self-checking bench for the serial block
`timescale 1ns/1ps
module tb_top;
  logic clk = 0, nrst = 0, cyc = 0, stb = 0, we = 0, ack, txd, txd_en, irq, rxd, m, t8;
  logic [11:0] adr = 0;
  logic [3:0] sel = 4'h1;
  logic [31:0] wdat = 0, rdat;
  logic [7:0] q, d, fine;
  logic [10:0] e;
  logic [11:0] ra [8] = '{12'h140, 12'h144, 12'h148, 12'h14C, 12'h150, 12'h154, 12'h158,
                          12'h15C};
  int failures = 0, num_checks = 0, cycles = 0, n, n0;
  asb_serial DUT (.CLK_SYS(clk), .NRST(nrst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .RXD(rxd), .TXD(txd), .TXD_EN(txd_en), .IRQ(irq));
  asb_node node (.clk(clk), .txd(txd), .rxd(rxd));
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      failures++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] g);
    num_checks++;
    if (g !== ex) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, g);
    end
  endtask
  task automatic wb(input logic w, input logic [11:0] a, input logic [7:0] dv);
    int k;
    k = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h000000, dv};
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 40);
    q = rdat[7:0];
    if (k == 40) begin
      failures++;
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  function automatic logic [10:0] frame_of(input logic wl, input logic b9, input logic [7:0] v);
    return wl ? {1'b1, b9, v, 1'b0} : {1'b0, 1'b1, v, 1'b0};
  endfunction
  initial begin
    d = 8'($urandom(62));
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      wb(1'b0, ra[i], 8'h00);
      if (i != 1) chk("reset_value", (i == 0) ? 8'hC0 : 8'h00, q);
    end
    wb(1'b1, 12'h148, d);
    wb(1'b0, 12'h148, 8'h00);
    chk("baud_divisors", d, q);
    wb(1'b1, 12'h148, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, 12'h150, 8'h80 >> i);
      chk("irq", {7'h00, i < 2}, {7'h00, irq});
    end
    $display("test registers done");
    for (int k = 0; k < 3; k++) begin
      m = (k == 1);
      fine = (k < 2) ? 8'h01 : 8'h00;
      d = 8'($urandom);
      t8 = 1'($urandom);
      wb(1'b1, 12'h150, 8'h00);
      wb(1'b1, 12'h15C, fine);
      wb(1'b1, 12'h14C, {1'b0, t8, 1'b0, m, 4'h0});
      node.bit_cyc = (k < 2) ? 16 : 32;
      node.nbits = m ? 11 : 10;
      n0 = node.nrx;
      wb(1'b1, 12'h150, 8'h08);
      wb(1'b0, 12'h140, 8'h00);
      wb(1'b1, 12'h144, d);
      for (int i = 0; i < 1000 && node.nrx == n0; i++) @(posedge clk);
      e = frame_of(m, t8, d);
      chk("tx_low", e[7:0], node.got[7:0]);
      chk("tx_high", {5'h00, e[10:8]}, {5'h00, node.got[10:8]});
    end
    node.bit_cyc = 16;
    wb(1'b1, 12'h15C, 8'h01);
    wb(1'b1, 12'h150, 8'h09);
    repeat (400) @(posedge clk);
    wb(1'b1, 12'h150, 8'h08);
    repeat (400) @(posedge clk);
    chk("break_data", 8'h00, node.got[8:1]);
    chk("break_stop", 8'h00, {7'h00, node.got[9]});
    chk("break_idle", 8'h01, {7'h00, txd});
    $display("test transmit done");
    wb(1'b1, 12'h154, 8'h01);
    wb(1'b1, 12'h150, 8'h2C);
    for (int k = 0; k < 4; k++) begin
      m = (k == 1);
      d = 8'($urandom);
      t8 = 1'($urandom);
      wb(1'b1, 12'h14C, {3'h0, m, k == 3, 3'h0});
      if (k == 3) begin
        wb(1'b1, 12'h150, 8'h2E);
        node.send(frame_of(1'b0, 1'b0, d & 8'h7F), 10);
        wb(1'b0, 12'h140, 8'h00);
        chk("muted_drop", 8'h00, q & 8'h20);
        d[7] = 1'b1;
      end
      e = frame_of(m, t8, d);
      if (k == 2) e[9] = 1'b0;
      node.send(e, m ? 11 : 10);
      n = 0;
      do begin
        wb(1'b0, 12'h140, 8'h00);
        n++;
      end while (q[5] !== 1'b1 && n < 100);
      chk("framing_flag", {7'h00, k == 2}, {7'h00, q[1]});
      chk("rx_irq", 8'h01, {7'h00, irq});
      wb(1'b0, 12'h144, 8'h00);
      chk("rx_holding_reg", d, q);
      if (k == 3) begin
        wb(1'b0, 12'h150, 8'h00);
        chk("mute_cleared", 8'h2C, q);
      end
      wb(1'b0, 12'h14C, 8'h00);
      if (m) chk("rx_ninth_bit", {7'h00, t8}, {7'h00, q[7]});
      wb(1'b0, 12'h140, 8'h00);
      chk("flags_cleared", 8'h00, q & 8'h2A);
    end
    $display("test receive done");
    tally_and_finish();
  end
endmodule

// ==== design/asb_serial.sv ====
// Asynchronous serial interface with Wishbone register access
`timescale 1ns/1ps

// How it works
// - Framing flag sets on bad stop bit or break; cleared by status then data read.
// - Framing flag alone raises no interrupt; with overrun only overrun is set.
// - Nine-bit mode stores received ninth bit in frame control.
// - Nine-bit mode sends frame control transmit ninth bit as data bit nine.
// - Word length 0 gives 1+8+1 bits, 1 gives 1+9+1 bits.
// - Wake field picks idle-line (0) or address-mark (1) wake-up.
// - Receive enable requests interrupt on overrun or receive ready.
// - Interrupt on tx empty, tx complete, idle when each enable is set.
// - Transmitter enable drives serial output pin; clear returns pin to port.
// - Transmitter enable low-high pulse sends preamble after current word.
// - Receiver enable starts start-bit hunt; clearing stops receiver.
// - Mute set and cleared by software, cleared by hardware on wake-up.
// - Break field sends break frames; clearing it sends one more break.
// - Data address writes transmit holding, reads receive holding register.
// - Prescaler field gives factor 1, 3, 4 or 13.
// - Transmit divisor field gives factor two to the field value.
// - Receive divisor field gives factor two to the field value.
// - Fine transmit divider nonzero replaces conventional transmit divisor.
// - Fine receive divider nonzero replaces conventional receive divisor.
// - Fine receive rate is clock over 16 times divider; off after reset.
// - Fine transmit rate is clock over 16 times divider.
// - Conventional rate is clock over 32, prescale and divide factors.
// - Address-mark wake on word with top bit 1, clears mute, sets ready.
// - Idle-line wake clears mute without setting idle flag.
module asb_serial #(
  parameter int ADR_W = 12
) (
  input wire logic CLK_SYS,
  input wire logic NRST,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [ADR_W-1:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic RXD,
  output logic TXD,
  output logic TXD_EN,
  output logic IRQ
);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (ADR_W < 12) begin : g_bad_adr
    $error("ADR_W must be at least 12");
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Clock cycles per bit for either direction
  function automatic logic [16:0] bit_cycles(input logic [1:0] pre, input logic [2:0] ex,
                                             input logic [7:0] fine);
    logic [4:0] pr;
    pr = asb_pkg::PRESCALE_0;
    case (pre)
      2'h0: pr = asb_pkg::PRESCALE_0;
      2'h1: pr = asb_pkg::PRESCALE_1;
      2'h2: pr = asb_pkg::PRESCALE_2;
      default: pr = asb_pkg::PRESCALE_3;
    endcase
    if (fine != 8'h00) begin
      bit_cycles = 17'(asb_pkg::FINE_BIT_DIV) * {9'h000, fine};
    end else begin
      bit_cycles = (17'(asb_pkg::CONV_BIT_DIV) * {12'h000, pr}) << ex;
    end
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  asb_pkg::asb_status_s status;
  asb_pkg::asb_line_ctl_s line_ctl;
  logic [7:0] frame_control;
  logic [7:0] baud_divisors;
  logic [7:0] fine_rx_divider_value;
  logic [7:0] fine_tx_divider_value;
  logic [7:0] tx_holding_reg;
  logic [7:0] rx_holding_reg;
  logic status_seen;

  logic word_len;
  logic wake_mark;
  assign word_len = frame_control[asb_pkg::FC_WORD_LEN];
  assign wake_mark = frame_control[asb_pkg::FC_WAKE];

  logic [3:0] frame_bits;
  assign frame_bits = word_len ? asb_pkg::BITS_LONG : asb_pkg::BITS_SHORT;

  // ----------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------
  logic bus_req;
  logic bus_wr;
  logic bus_rd;
  logic [9:0] idx;
  assign bus_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  assign bus_wr = bus_req & WB_WE_I & WB_SEL_I[0];
  assign bus_rd = bus_req & ~WB_WE_I;
  assign idx = WB_ADR_I[11:2];

  logic hit_status;
  logic hit_data;
  assign hit_status = (idx == asb_pkg::IDX_LINE_STATUS);
  assign hit_data = (idx == asb_pkg::IDX_DATA_WINDOW);

  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      WB_ACK_O <= 1'b0;
    end else begin
      WB_ACK_O <= bus_req;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      WB_DAT_O <= 32'h0000_0000;
    end else if (bus_rd) begin
      if (hit_status) begin
        WB_DAT_O <= {24'h000000, status};
      end else if (hit_data) begin
        WB_DAT_O <= {24'h000000, rx_holding_reg};
      end else if (idx == asb_pkg::IDX_BAUD_DIVISORS) begin
        WB_DAT_O <= {24'h000000, baud_divisors};
      end else if (idx == asb_pkg::IDX_FRAME_CONTROL) begin
        WB_DAT_O <= {24'h000000, frame_control[7:6], 1'b0, frame_control[4:3], 3'h0};
      end else if (idx == asb_pkg::IDX_LINE_CONTROL) begin
        WB_DAT_O <= {24'h000000, line_ctl};
      end else if (idx == asb_pkg::IDX_FINE_RX_DIVIDER) begin
        WB_DAT_O <= {24'h000000, fine_rx_divider_value};
      end else if (idx == asb_pkg::IDX_FINE_TX_DIVIDER) begin
        WB_DAT_O <= {24'h000000, fine_tx_divider_value};
      end else begin
        WB_DAT_O <= 32'h0000_0000;
      end
    end
  end

  // Status access arms the clearing sequence
  logic rd_clear;
  logic wr_clear;
  assign rd_clear = bus_rd & hit_data & status_seen;
  assign wr_clear = bus_wr & hit_data & status_seen;

  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      status_seen <= 1'b0;
    end else if (bus_req & hit_status) begin
      status_seen <= 1'b1;
    end else if (bus_req & hit_data) begin
      status_seen <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  logic hw_unmute;

  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      line_ctl <= asb_pkg::RST_LINE_CONTROL;
    end else begin
      if (bus_wr && idx == asb_pkg::IDX_LINE_CONTROL) begin
        line_ctl <= WB_DAT_I[7:0];
      end
      if (hw_unmute) begin
        line_ctl.mute_select <= 1'b0;
      end
    end
  end

  logic rx_ninth_set;
  logic rx_ninth_bit;

  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      frame_control <= asb_pkg::RST_FRAME_CONTROL;
      baud_divisors <= asb_pkg::RST_BAUD_DIVISORS;
      fine_rx_divider_value <= asb_pkg::RST_FINE_DIVIDER;
      fine_tx_divider_value <= asb_pkg::RST_FINE_DIVIDER;
    end else begin
      if (bus_wr && idx == asb_pkg::IDX_FRAME_CONTROL) begin
        frame_control[6:3] <= WB_DAT_I[6:3];
      end
      if (rx_ninth_set) begin
        frame_control[asb_pkg::FC_RX_NINTH] <= rx_ninth_bit;
      end
      if (bus_wr && idx == asb_pkg::IDX_BAUD_DIVISORS) begin
        baud_divisors <= WB_DAT_I[7:0];
      end
      if (bus_wr && idx == asb_pkg::IDX_FINE_RX_DIVIDER) begin
        fine_rx_divider_value <= WB_DAT_I[7:0];
      end
      if (bus_wr && idx == asb_pkg::IDX_FINE_TX_DIVIDER) begin
        fine_tx_divider_value <= WB_DAT_I[7:0];
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      tx_holding_reg <= 8'h00;
    end else if (bus_wr && hit_data) begin
      tx_holding_reg <= WB_DAT_I[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------
  typedef enum logic {TX_IDLE, TX_SHIFT} asb_tx_e;
  asb_tx_e tx_state;
  logic [16:0] tx_cnt;
  logic [3:0] tx_bit;
  logic [10:0] tx_shift;
  logic te_prev;
  logic sbk_prev;
  logic preamble_pending;
  logic break_pending;
  logic tx_load;
  logic tx_done;
  logic [16:0] tx_period;

  assign tx_period = bit_cycles(baud_divisors[7:6], baud_divisors[5:3], fine_tx_divider_value);
  assign tx_load = (tx_state == TX_IDLE) & line_ctl.transmitter_on &
                   (line_ctl.send_break_ctl | break_pending | preamble_pending |
                    ~status.tx_empty_flag);
  assign tx_done = (tx_state == TX_SHIFT) & (tx_cnt == tx_period - 17'h1) &
                   (tx_bit == frame_bits - 4'h1);

  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      te_prev <= 1'b0;
      sbk_prev <= 1'b0;
      preamble_pending <= 1'b0;
      break_pending <= 1'b0;
    end else begin
      te_prev <= line_ctl.transmitter_on;
      sbk_prev <= line_ctl.send_break_ctl;
      if (line_ctl.transmitter_on & ~te_prev) begin
        preamble_pending <= 1'b1;
      end else if (tx_load & ~line_ctl.send_break_ctl & ~break_pending) begin
        preamble_pending <= 1'b0;
      end
      if (sbk_prev & ~line_ctl.send_break_ctl) begin
        break_pending <= 1'b1;
      end else if (tx_load) begin
        break_pending <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      tx_state <= TX_IDLE;
      tx_cnt <= 17'h00000;
      tx_bit <= 4'h0;
      tx_shift <= 11'h7FF;
    end else begin
      case (tx_state)
        TX_IDLE: begin
          tx_cnt <= 17'h00000;
          tx_bit <= 4'h0;
          if (tx_load) begin
            tx_state <= TX_SHIFT;
            if (line_ctl.send_break_ctl | break_pending) begin
              tx_shift <= 11'h000;
            end else if (preamble_pending) begin
              tx_shift <= 11'h7FF;
            end else begin
              tx_shift <= {1'b1, word_len ? frame_control[asb_pkg::FC_TX_NINTH] : 1'b1,
                           tx_holding_reg, 1'b0};
            end
          end
        end
        default: begin
          if (tx_cnt == tx_period - 17'h1) begin
            tx_cnt <= 17'h00000;
            tx_shift <= {1'b1, tx_shift[10:1]};
            if (tx_bit == frame_bits - 4'h1) begin
              tx_state <= TX_IDLE;
            end else begin
              tx_bit <= tx_bit + 4'h1;
            end
          end else begin
            tx_cnt <= tx_cnt + 17'h1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      TXD <= 1'b1;
      TXD_EN <= 1'b0;
    end else begin
      TXD <= (tx_state == TX_SHIFT) ? tx_shift[0] : 1'b1;
      TXD_EN <= line_ctl.transmitter_on;
    end
  end

  logic tx_data_load;
  assign tx_data_load = tx_load & ~line_ctl.send_break_ctl & ~break_pending &
                        ~preamble_pending;

  // ----------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------
  typedef enum logic {RX_HUNT, RX_BITS} asb_rx_e;
  asb_rx_e rx_state;
  logic [16:0] rx_div;
  logic [16:0] rx_period;
  logic rx_tick;
  logic [3:0] rx_samp;
  logic [3:0] rx_bit;
  logic [1:0] rx_votes;
  logic [10:0] rx_shift;
  logic rx_noise;
  logic [7:0] idle_cnt;
  logic idle_armed;
  logic maj;
  logic vote_noise;
  logic [10:0] word;
  logic word_end;
  logic word_take;
  logic ovr_set;
  logic idle_seen;

  assign rx_period = bit_cycles(baud_divisors[7:6], baud_divisors[2:0], fine_rx_divider_value)
                     >> 4;
  assign rx_tick = line_ctl.receiver_on & (rx_div == rx_period - 17'h1);
  assign maj = (rx_votes[0] & rx_votes[1]) | (rx_votes[0] & RXD) | (rx_votes[1] & RXD);
  assign vote_noise = ~((rx_votes[0] == rx_votes[1]) & (rx_votes[1] == RXD));
  assign word = {maj, rx_shift[10:1]};
  assign word_end = rx_tick & (rx_state == RX_BITS) & (rx_samp == asb_pkg::SAMPLE_C) &
                    (rx_bit == frame_bits - 4'h1);
  // Muted words dropped unless address mark wakes the receiver
  assign word_take = word_end & (~line_ctl.mute_select | (wake_mark & word[9]));
  assign ovr_set = word_take & status.rx_ready_flag;
  assign idle_seen = rx_tick & (rx_state == RX_HUNT) & RXD &
                     (idle_cnt == {frame_bits, 4'h0} - 8'h01);
  assign hw_unmute = line_ctl.mute_select &
                     ((word_take & wake_mark) | (idle_seen & ~wake_mark));
  assign rx_ninth_set = word_take & ~ovr_set & word_len;
  assign rx_ninth_bit = word[9];

  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      rx_div <= 17'h00000;
    end else if (!line_ctl.receiver_on || rx_tick) begin
      rx_div <= 17'h00000;
    end else begin
      rx_div <= rx_div + 17'h1;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      rx_state <= RX_HUNT;
      rx_samp <= 4'h0;
      rx_bit <= 4'h0;
      rx_votes <= 2'h0;
      rx_shift <= 11'h000;
      rx_noise <= 1'b0;
    end else if (!line_ctl.receiver_on) begin
      rx_state <= RX_HUNT;
    end else if (rx_tick) begin
      case (rx_state)
        RX_HUNT: begin
          rx_samp <= 4'h1;
          rx_bit <= 4'h0;
          rx_noise <= 1'b0;
          if (!RXD) begin
            rx_state <= RX_BITS;
          end
        end
        default: begin
          rx_samp <= rx_samp + 4'h1;
          if (rx_samp == asb_pkg::SAMPLE_A) begin
            rx_votes[0] <= RXD;
          end
          if (rx_samp == asb_pkg::SAMPLE_B) begin
            rx_votes[1] <= RXD;
          end
          if (rx_samp == asb_pkg::SAMPLE_C) begin
            rx_shift <= word;
            rx_noise <= rx_noise | vote_noise;
            if ((rx_bit == 4'h0 && maj) || rx_bit == frame_bits - 4'h1) begin
              rx_state <= RX_HUNT;
            end
          end
          if (rx_samp == 4'hF) begin
            rx_bit <= rx_bit + 4'h1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      idle_cnt <= 8'h00;
    end else if (!line_ctl.receiver_on || rx_state != RX_HUNT || !RXD) begin
      idle_cnt <= 8'h00;
    end else if (rx_tick && idle_cnt != {frame_bits, 4'h0}) begin
      idle_cnt <= idle_cnt + 8'h01;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      rx_holding_reg <= 8'h00;
    end else if (word_take && !ovr_set) begin
      rx_holding_reg <= word_len ? word[8:1] : word[9:2];
    end
  end

  // ----------------------------------------------------------------
  // Status flags: a setting event wins over the clearing access
  // ----------------------------------------------------------------
  logic rdy_set;
  logic fe_set;
  logic nf_set;
  logic idle_set;
  assign rdy_set = word_take & ~ovr_set;
  assign fe_set = rdy_set & ~maj;
  assign nf_set = rdy_set & (rx_noise | vote_noise);
  assign idle_set = idle_seen & idle_armed & ~line_ctl.mute_select;

  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      idle_armed <= 1'b0;
    end else if (rdy_set) begin
      idle_armed <= 1'b1;
    end else if (idle_set) begin
      idle_armed <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      status <= asb_pkg::RST_LINE_STATUS;
    end else begin
      status.tx_empty_flag <= tx_data_load | (status.tx_empty_flag & ~wr_clear);
      status.tx_complete_flag <= tx_done | (status.tx_complete_flag & ~wr_clear);
      status.rx_ready_flag <= rdy_set | (status.rx_ready_flag & ~rd_clear);
      status.idle_flag <= idle_set | (status.idle_flag & ~rd_clear);
      status.overrun_flag <= ovr_set | (status.overrun_flag & ~rd_clear);
      status.noise_flag <= nf_set | (status.noise_flag & ~rd_clear);
      status.framing_flag <= fe_set | (status.framing_flag & ~rd_clear);
      status.unused <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt request
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= (line_ctl.tx_empty_irq_en & status.tx_empty_flag) |
             (line_ctl.tx_complete_irq_en & status.tx_complete_flag) |
             (line_ctl.rx_irq_en & (status.overrun_flag | status.rx_ready_flag)) |
             (line_ctl.idle_irq_en & status.idle_flag);
    end
  end

endmodule

// ==== shared/asb_pkg.sv ====
// Constants and carrier types for the asynchronous serial block
package asb_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [9:0] IDX_LINE_STATUS = 10'h050;
  localparam logic [9:0] IDX_DATA_WINDOW = 10'h051;
  localparam logic [9:0] IDX_BAUD_DIVISORS = 10'h052;
  localparam logic [9:0] IDX_FRAME_CONTROL = 10'h053;
  localparam logic [9:0] IDX_LINE_CONTROL = 10'h054;
  localparam logic [9:0] IDX_FINE_RX_DIVIDER = 10'h055;
  localparam logic [9:0] IDX_FINE_TX_DIVIDER = 10'h057;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_LINE_STATUS = 8'hC0;
  localparam logic [7:0] RST_LINE_CONTROL = 8'h00;
  localparam logic [7:0] RST_FRAME_CONTROL = 8'h00;
  localparam logic [7:0] RST_BAUD_DIVISORS = 8'h00;
  localparam logic [7:0] RST_FINE_DIVIDER = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int FC_RX_NINTH = 7;
  localparam int FC_TX_NINTH = 6;
  localparam int FC_WORD_LEN = 4;
  localparam int FC_WAKE = 3;
  localparam int BR_PRESCALER_LSB = 6;
  localparam int BR_TX_DIV_LSB = 3;
  localparam int BR_RX_DIV_LSB = 0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CONV_BIT_DIV = 32;
  localparam int FINE_BIT_DIV = 16;
  localparam int OVERSAMPLE = 16;
  localparam logic [3:0] SAMPLE_A = 4'h7;
  localparam logic [3:0] SAMPLE_B = 4'h8;
  localparam logic [3:0] SAMPLE_C = 4'h9;
  localparam logic [3:0] BITS_SHORT = 4'hA;
  localparam logic [3:0] BITS_LONG = 4'hB;
  localparam logic [4:0] PRESCALE_0 = 5'h01;
  localparam logic [4:0] PRESCALE_1 = 5'h03;
  localparam logic [4:0] PRESCALE_2 = 5'h04;
  localparam logic [4:0] PRESCALE_3 = 5'h0D;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic tx_empty_flag;
    logic tx_complete_flag;
    logic rx_ready_flag;
    logic idle_flag;
    logic overrun_flag;
    logic noise_flag;
    logic framing_flag;
    logic unused;
  } asb_status_s;

  typedef struct packed {
    logic tx_empty_irq_en;
    logic tx_complete_irq_en;
    logic rx_irq_en;
    logic idle_irq_en;
    logic transmitter_on;
    logic receiver_on;
    logic mute_select;
    logic send_break_ctl;
  } asb_line_ctl_s;

  typedef enum logic [1:0] {
    FRAME_DATA,
    FRAME_PREAMBLE,
    FRAME_BREAK
  } asb_frame_e;

endpackage
